// >>> rtl/sssm_monitor.sv
// sssm_monitor: safe stop with ramp or accel watch, plus four-level speed cap
// assumes speed and selects come from logic on sys_clk; APB3 slave, no waits
//
// Overview of operation
// R1: in safe stop, cut torque at shutdown speed
// R2: enable bit gates all extended functions
// R3: mode code 1 ramp watch, code 3 accel
// R4: ramp slope from reference speed and time
// R5: configurable ramp delay, default 250 ms
// R6: ramp starts after delay from captured setpoint
// R7: flag high while safe stop active
// R8: flag high while ramp or accel watch runs
// R9: cut torque on standstill or shutdown speed
// R10: accel threshold tracks speed plus tolerance
// R11: accel threshold lowered down to shutdown speed
// R12: accel cut on shutdown speed or timeout
// R13: selecting speed cap brakes on quick stop ramp
// R14: cap mode 3 no ramp, 1 ramp watch
// R15: four cap levels, selected one is limit
// R16: without safety fieldbus use level one only; capLevel still selects any of the four levels here
// R17: clamp setpoint to level times percent
// R18: cap select delay only without ramp watch
// R19: per-level response: 0 cut, 1 brake
// R20: flag high while speed cap active
// R21: evaluate once per monitoring cycle, speed magnitude
`timescale 1ns/1ps
module sssm_monitor
   import sssm_pkg::*;
#(
   parameter int TICK_CYC = MON_CYCLE_CYC
) (
   // clock and reset
   input  wire logic               sys_clk,
   input  wire logic               rst_b,
   // apb slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // control system side
   input  wire logic signed [15:0] measSpeed,
   input  wire logic signed [15:0] speedSetpoint,
   input  wire logic               stopSelect,
   input  wire logic               capSelect,
   input  wire logic [1:0]         capLevel,
   // drive side
   output logic                    torqueCut,
   output logic                    quickStopRamp,
   output logic                    stopOneActive,
   output logic                    rampOrAccelActive,
   output logic                    speedCapActive,
   output logic signed [15:0]      clampedSetpoint
);
   sssm_state_type state_reg, state_next;
   logic        fnEnable_reg;
   logic [1:0]  mode_reg;
   logic [15:0] shutSpd_reg, accShut_reg, refSpd_reg, rampDly_reg, rampMon_reg;
   logic [15:0] stillSpd_reg, stillMs_reg, tol_reg, capDly_reg;
   logic [31:0] brakeCut_reg;
   logic [7:0]  capPct_reg;
   logic [3:0]  capResp_reg;
   logic [15:0] level_reg [4];
   logic [15:0] tickCnt_reg;
   logic        tick_reg;
   logic [31:0] timer_reg;
   logic [15:0] stillCnt_reg;
   logic [15:0] thr_reg, startSpd_reg;
   logic [16:0] acc_reg;
   logic        capFault_reg;
   logic [15:0] absSpeed, absSet, level, capLim, trackThr;
   logic [23:0] capProd;
   logic [31:0] timerInc;
   logic        stopReq, stillMet, atShut, wrEn, rdPhase, mapped;
   logic [31:0] rdData;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   // apb: registered answer, one access cycle, no wait states
   assign wrEn    = psel & penable & pready & pwrite;
   assign rdPhase = psel & ~penable;
   always_comb begin
      mapped = 1'b1;
      rdData = 32'h00000000;
      case (paddr)
         A_CTRL:   rdData = {28'h0000000, 1'b0, mode_reg, fnEnable_reg};
         A_SHUT:   rdData = {accShut_reg, shutSpd_reg};
         A_RAMP:   rdData = {rampDly_reg, refSpd_reg};
         A_RTIME:  rdData = {stillMs_reg, rampMon_reg};
         A_STILL:  rdData = {tol_reg, stillSpd_reg};
         A_BCUT:   rdData = brakeCut_reg;
         A_CAPCFG: rdData = {capDly_reg, 4'h0, capResp_reg, capPct_reg};
         A_STAT:   rdData = {thr_reg, 9'h000, capFault_reg, state_reg,
                             speedCapActive, rampOrAccelActive, stopOneActive};
         A_CLAMP:  rdData = {16'h0000, clampedSetpoint};
         default: begin
            mapped = 1'b0;
            for (int i = 0; i < 4; i++) begin
               if (paddr == A_LVL0 + 8'(4 * i)) begin
                  mapped = 1'b1;
                  rdData = {16'h0000, level_reg[i]};
               end
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready  <= rdPhase;
         pslverr <= rdPhase & ~mapped;
         if (rdPhase)
            prdata <= pwrite ? 32'h00000000 : rdData;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         fnEnable_reg <= 1'b0;
         mode_reg     <= RST_MODE;
         shutSpd_reg  <= RST_SHUT_RPM;
         accShut_reg  <= RST_ASHUT_RPM;
         refSpd_reg   <= RST_REF_RPM;
         rampDly_reg  <= RST_RDLY_MS;
         rampMon_reg  <= RST_RMON_MS;
         stillSpd_reg <= RST_STILL_RPM;
         stillMs_reg  <= RST_STILL_MS;
         tol_reg      <= RST_TOL_RPM;
         brakeCut_reg <= RST_BCUT_MS;
         capPct_reg   <= RST_CAP_PCT;
         capDly_reg   <= RST_CDLY_MS;
         capResp_reg  <= RST_CAP_RESP;
      end else if (wrEn) begin
         case (paddr)
            A_CTRL: begin
               fnEnable_reg <= pwdata[0];
               // R3 only codes 1 and 3 are kept
               if (pwdata[2:1] == MODE_RAMP || pwdata[2:1] == MODE_ACCEL)
                  mode_reg <= pwdata[2:1];
            end
            A_SHUT: begin
               shutSpd_reg <= pwdata[15:0];
               accShut_reg <= pwdata[31:16];
            end
            A_RAMP: begin
               refSpd_reg  <= pwdata[15:0];
               rampDly_reg <= pwdata[31:16];
            end
            A_RTIME: begin
               // zero time would make the ramp divider step on every cycle
               if (pwdata[15:0] != 16'h0000)
                  rampMon_reg <= pwdata[15:0];
               stillMs_reg <= pwdata[31:16];
            end
            A_STILL: begin
               stillSpd_reg <= pwdata[15:0];
               tol_reg      <= pwdata[31:16];
            end
            A_BCUT: brakeCut_reg <= pwdata;
            A_CAPCFG: begin
               capPct_reg  <= pwdata[7:0];
               capResp_reg <= pwdata[11:8];
               capDly_reg  <= pwdata[31:16];
            end
            default: ;
         endcase
      end
   end

   // R15 one register per cap level
   for (genvar g = 0; g < 4; g++) begin : gLvl
      always_ff @(posedge sys_clk or negedge rst_b) begin
         if (!rst_b)
            level_reg[g] <= RST_LVL_RPM;
         else if (wrEn && paddr == A_LVL0 + 8'(4 * g))
            level_reg[g] <= pwdata[15:0];
      end
   end

   // R21 monitoring cycle enable
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tickCnt_reg <= 16'h0000;
         tick_reg    <= 1'b0;
      end else begin
         tick_reg    <= (tickCnt_reg == 16'(TICK_CYC - 1));
         tickCnt_reg <= (tickCnt_reg == 16'(TICK_CYC - 1)) ? 16'h0000
                        : tickCnt_reg + 16'h0001;
      end
   end

   // R21 magnitudes; -32768 maps to 32768 unsigned
   assign absSpeed = measSpeed[15] ? 16'(-measSpeed) : 16'(measSpeed);
   assign absSet   = speedSetpoint[15] ? 16'(-speedSetpoint) : 16'(speedSetpoint);
   // R16 level chosen by the party outside; other levels still work
   assign level    = level_reg[capLevel];
   assign capProd  = level * capPct_reg;
   assign capLim   = 16'(capProd / PCT_DIV);
   assign timerInc = timer_reg + 32'h00000001;
   assign atShut   = absSpeed <= shutSpd_reg;
   assign stillMet = stillCnt_reg >= stillMs_reg;
   // R19 brake response turns a cap fault into a stop request
   assign stopReq  = stopSelect | (capFault_reg & capResp_reg[capLevel]);
   // R10 candidate threshold, saturating
   assign trackThr = (17'(absSpeed) + 17'(tol_reg) > 17'h0FFFF) ? 16'hFFFF
                     : absSpeed + tol_reg;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         S_IDLE: begin
            if (stopReq)
               state_next = (mode_reg == MODE_ACCEL) ? S_ACCEL : S_DELAY;
            else if (capSelect)
               state_next = S_CDELAY;
         end
         S_DELAY: begin
            if (!stopReq)
               state_next = S_IDLE;
            else if (atShut || stillMet)
               state_next = S_CUT;
            // R5 ramp watch waits out the delay
            else if (timerInc >= 32'(rampDly_reg))
               state_next = S_RAMP;
         end
         S_RAMP: begin
            if (!stopReq)
               state_next = S_IDLE;
            // R1 R9 shutdown speed or standstill ends the stop
            else if (atShut || stillMet || absSpeed > thr_reg)
               state_next = S_CUT;
         end
         S_ACCEL: begin
            if (!stopReq)
               state_next = S_IDLE;
            // R12 first of speed or timeout wins
            else if (atShut || timerInc >= brakeCut_reg)
               state_next = S_CUT;
            else if (absSpeed > thr_reg && absSpeed > accShut_reg)
               state_next = S_CUT;
         end
         S_CUT: begin
            if (!stopSelect && !capFault_reg)
               state_next = S_IDLE;
         end
         S_CDELAY: begin
            if (stopReq)
               state_next = S_IDLE;
            else if (!capSelect)
               state_next = S_IDLE;
            // R18 R14 select delay only without ramp watch
            else if (mode_reg == MODE_ACCEL && timerInc >= 32'(capDly_reg))
               state_next = S_CAPON;
            else if (mode_reg == MODE_RAMP && timerInc >= 32'(rampDly_reg))
               state_next = S_CRAMP;
         end
         S_CRAMP: begin
            if (stopReq || !capSelect)
               state_next = S_IDLE;
            else if (absSpeed > thr_reg)
               state_next = S_CUT;
            else if (absSpeed <= level)
               state_next = S_CAPON;
         end
         S_CAPON: begin
            if (stopReq || !capSelect)
               state_next = S_IDLE;
            // R19 immediate response cuts at once
            else if (absSpeed > level && !capResp_reg[capLevel])
               state_next = S_CUT;
         end
         default: state_next = S_IDLE;
      endcase
   end

   // R2 disable forces idle at once; otherwise moves only on ticks
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b)
         state_reg <= S_IDLE;
      else if (!fnEnable_reg)
         state_reg <= S_IDLE;
      else if (tick_reg)
         state_reg <= state_next;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b)
         capFault_reg <= 1'b0;
      else if (!fnEnable_reg || !capSelect)
         capFault_reg <= 1'b0;
      else if (tick_reg && state_reg == S_CAPON && absSpeed > level)
         capFault_reg <= 1'b1;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b)
         timer_reg <= 32'h00000000;
      else if (tick_reg)
         timer_reg <= (state_next != state_reg) ? 32'h00000000 : timerInc;
   end

   // R9 standstill must hold for the standstill time
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b)
         stillCnt_reg <= 16'h0000;
      else if (tick_reg) begin
         if (absSpeed >= stillSpd_reg)
            stillCnt_reg <= 16'h0000;
         else if (!stillMet)
            stillCnt_reg <= stillCnt_reg + 16'h0001;
      end
   end

   // R6 setpoint captured at selection
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b)
         startSpd_reg <= 16'h0000;
      else if (tick_reg && state_reg == S_IDLE)
         startSpd_reg <= absSet;
   end

   // threshold engine; ramp falls at most 1 rpm per cycle, so steep ramps are capped
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         thr_reg <= 16'h0000;
         acc_reg <= 17'h00000;
      end else if (tick_reg) begin
         if (state_reg == S_IDLE) begin
            thr_reg <= trackThr;
            acc_reg <= 17'h00000;
         end else if (state_reg == S_DELAY || state_reg == S_CDELAY) begin
            thr_reg <= startSpd_reg;
         end else if (state_reg == S_RAMP || state_reg == S_CRAMP) begin
            // R4 slope is reference speed over monitor time
            if (acc_reg + 17'(refSpd_reg) >= 17'(rampMon_reg)) begin
               acc_reg <= acc_reg + 17'(refSpd_reg) - 17'(rampMon_reg);
               if (thr_reg != 16'h0000)
                  thr_reg <= thr_reg - 16'h0001;
            end else begin
               acc_reg <= acc_reg + 17'(refSpd_reg);
            end
         end else if (state_reg == S_ACCEL) begin
            // R10 R11 follow speed down, never below shutdown speed
            if (trackThr < thr_reg)
               thr_reg <= (trackThr < shutSpd_reg) ? shutSpd_reg : trackThr;
            else if (thr_reg < shutSpd_reg)
               thr_reg <= shutSpd_reg;
         end
      end
   end

   // outputs track the state the register is about to take
   sssm_state_type stNx;
   assign stNx = !fnEnable_reg ? S_IDLE : (tick_reg ? state_next : state_reg);
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         torqueCut         <= 1'b0;
         quickStopRamp     <= 1'b0;
         stopOneActive     <= 1'b0;
         rampOrAccelActive <= 1'b0;
         speedCapActive    <= 1'b0;
      end else begin
         torqueCut         <= stNx == S_CUT;
         // R13 brake on quick stop ramp after stop or cap select
         quickStopRamp     <= stNx inside {S_DELAY, S_RAMP, S_ACCEL, S_CDELAY, S_CRAMP};
         // R7 stop flag
         stopOneActive     <= stNx inside {S_DELAY, S_RAMP, S_ACCEL};
         // R8 watch flag
         rampOrAccelActive <= stNx inside {S_RAMP, S_ACCEL, S_CRAMP};
         // R20 cap flag
         speedCapActive    <= stNx == S_CAPON;
      end
   end

   // R17 clamp keeps the sign of the setpoint
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b)
         clampedSetpoint <= 16'sh0000;
      else if (stNx inside {S_CDELAY, S_CRAMP, S_CAPON} && absSet > capLim)
         clampedSetpoint <= speedSetpoint[15] ? 16'(-capLim) : capLim;
      else
         clampedSetpoint <= speedSetpoint;
   end

   chk_cut_shutdown: assert property ( // R1
      fnEnable_reg && tick_reg && state_reg == S_RAMP && stopReq && atShut
      |=> torqueCut && !stopOneActive)
      else $error("no torque cut at shutdown speed");
   chk_disable_idle: assert property ( // R2
      !fnEnable_reg |=> !torqueCut && !quickStopRamp && !speedCapActive)
      else $error("functions active while disabled");
   chk_mode_accel: assert property ( // R3
      fnEnable_reg && tick_reg && state_reg == S_IDLE && stopReq && mode_reg == MODE_ACCEL
      |=> state_reg == S_ACCEL && rampOrAccelActive)
      else $error("accel mode not entered");
   chk_ramp_falls: assert property ( // R4
      state_reg == S_RAMP && $past(state_reg) == S_RAMP |-> thr_reg <= $past(thr_reg))
      else $error("ramp threshold rose");
   chk_ramp_start: assert property ( // R6
      $rose(state_reg == S_RAMP) |-> thr_reg == startSpd_reg && timer_reg == 32'h00000000)
      else $error("ramp did not start at captured setpoint");
   chk_delay_wait: assert property ( // R5
      $rose(state_reg == S_RAMP) |-> $past(timer_reg) + 32'h00000001 >= 32'(rampDly_reg))
      else $error("ramp watch began before delay");
   chk_stop_flag: assert property ( // R7
      $rose(stopOneActive) |-> state_reg inside {S_DELAY, S_ACCEL} && quickStopRamp)
      else $error("stop flag without stop state");
   chk_accel_floor: assert property ( // R11
      state_reg == S_ACCEL && $past(state_reg) == S_ACCEL |-> thr_reg >= $past(shutSpd_reg))
      else $error("accel threshold below shutdown speed");
   chk_accel_track: assert property ( // R10
      state_reg == S_ACCEL && $past(state_reg) == S_ACCEL
      && $past(thr_reg) >= $past(shutSpd_reg) |-> thr_reg <= $past(thr_reg))
      else $error("accel threshold rose while tracking");
   chk_accel_timeout: assert property ( // R12
      fnEnable_reg && tick_reg && state_reg == S_ACCEL && stopReq && timerInc >= brakeCut_reg
      |=> torqueCut)
      else $error("accel timeout did not cut torque");
   chk_cap_cut: assert property ( // R19
      fnEnable_reg && tick_reg && state_reg == S_CAPON && capSelect && !stopReq
      && absSpeed > level && !capResp_reg[capLevel] |=> torqueCut ##1 torqueCut)
      else $error("immediate cap response missing");
   chk_cap_flag: assert property ( // R20
      speedCapActive |-> state_reg == S_CAPON && !stopOneActive)
      else $error("cap flag without cap state");

   cov_ramp_cut: cover property ($past(state_reg) == S_RAMP && state_reg == S_CUT);
   cov_accel_cut: cover property ($past(state_reg) == S_ACCEL && state_reg == S_CUT);
   cov_cap_on: cover property ($rose(speedCapActive));
   cov_cap_brake: cover property ($past(state_reg) == S_CAPON && state_reg == S_DELAY);
endmodule : sssm_monitor

// >>> rtl/sssm_pkg.sv
// sssm_pkg: constants for the safe stop and speed cap monitor
// assumes one 40 MHz clock; speeds are signed rpm, timers count ms
package sssm_pkg;
   localparam int CLK_FREQ_HZ   = 40_000_000;
   localparam int MON_CYCLE_US  = 1000;
   localparam int MON_CYCLE_CYC = MON_CYCLE_US * (CLK_FREQ_HZ / 1_000_000);
   // register byte offsets
   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_SHUT   = 8'h04;
   localparam logic [7:0] A_RAMP   = 8'h08;
   localparam logic [7:0] A_RTIME  = 8'h0C;
   localparam logic [7:0] A_STILL  = 8'h10;
   localparam logic [7:0] A_BCUT   = 8'h14;
   localparam logic [7:0] A_CAPCFG = 8'h18;
   localparam logic [7:0] A_LVL0   = 8'h1C;
   localparam logic [7:0] A_STAT   = 8'h2C;
   localparam logic [7:0] A_CLAMP  = 8'h30;
   // monitoring mode codes
   localparam logic [1:0] MODE_RAMP  = 2'h1;
   localparam logic [1:0] MODE_ACCEL = 2'h3;
   // values after reset
   localparam logic [1:0]  RST_MODE      = MODE_RAMP;
   localparam logic [15:0] RST_SHUT_RPM  = 16'h000A;
   localparam logic [15:0] RST_ASHUT_RPM = 16'h0000;
   localparam logic [15:0] RST_REF_RPM   = 16'h05DC;
   localparam logic [15:0] RST_RDLY_MS   = 16'h00FA;
   localparam logic [15:0] RST_RMON_MS   = 16'h2710;
   localparam logic [15:0] RST_STILL_RPM = 16'h0014;
   localparam logic [15:0] RST_STILL_MS  = 16'h0004;
   localparam logic [15:0] RST_TOL_RPM   = 16'h012C;
   localparam logic [31:0] RST_BCUT_MS   = 32'h000927C0;
   localparam logic [7:0]  RST_CAP_PCT   = 8'h50;
   localparam logic [15:0] RST_CDLY_MS   = 16'h0064;
   localparam logic [3:0]  RST_CAP_RESP  = 4'h0;
   localparam logic [15:0] RST_LVL_RPM   = 16'h07D0;
   localparam logic [23:0] PCT_DIV       = 24'h000064;
   typedef enum logic [2:0] {
      S_IDLE, S_DELAY, S_RAMP, S_ACCEL, S_CUT, S_CDELAY, S_CRAMP, S_CAPON
   } sssm_state_type;
endpackage : sssm_pkg

// >>> sim/sssm_drive_model.sv
// sssm_drive_model: motor feedback seen by the monitor
// assumes monitor outputs are registered on sys_clk
`timescale 1ns/1ps
module sssm_drive_model (
   // clock and reset
   input  wire logic               sys_clk,
   input  wire logic               rst_b,
   // monitor outputs and decelRate from the bench
   input  wire logic               torqueCut,
   input  wire logic               quickStopRamp,
   input  wire logic signed [15:0] clampedSetpoint,
   input  wire logic [3:0]         decelRate,
   // speed feedback
   output logic signed [15:0]      measSpeed
);
   logic signed [15:0] target;
   logic signed [15:0] step;
   always_comb begin
      target = (torqueCut || quickStopRamp) ? 16'sh0000 : clampedSetpoint;
      step   = (quickStopRamp && !torqueCut) ? {12'h000, decelRate} : 16'sh0004;
   end
   // zero brake rate holds speed, to starve the stop timer
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         measSpeed <= 16'sh0000;
      end else if (measSpeed < target - step) begin
         measSpeed <= measSpeed + step;
      end else if (measSpeed > target + step) begin
         measSpeed <= measSpeed - step;
      end else begin
         measSpeed <= target;
      end
   end
endmodule : sssm_drive_model

// >>> sim/tb_sssm_monitor.sv
// tb_sssm_monitor: register, safe stop and speed cap scenarios over APB
// assumes TICK_CYC of 4, so one ms is four clocks
`timescale 1ns/1ps
module tb_sssm_monitor
   import sssm_pkg::*;
();
   logic               sys_clk, rst_b, psel, penable, pwrite, pready, pslverr;
   logic               stopSelect, capSelect, torqueCut, quickStopRamp;
   logic               stopOneActive, rampOrAccelActive, speedCapActive, errBit;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata, rdData;
   logic signed [15:0] measSpeed, speedSetpoint, clampedSetpoint;
   logic [1:0]         capLevel;
   logic [3:0]         decelRate;
   int                 numErrors = 0, numChecks = 0, cycles = 0, cnt;
   wire logic [4:0]    outs = {~torqueCut, speedCapActive, rampOrAccelActive,
                               stopOneActive, torqueCut};
   localparam logic [7:0] RA [11] = '{A_CTRL, A_SHUT, A_RAMP, A_RTIME, A_STILL,
      A_BCUT, A_CAPCFG, A_LVL0, A_LVL0 + 8'h04, A_LVL0 + 8'h08, A_LVL0 + 8'h0C};
   localparam logic [31:0] RV [11] = '{32'h00000002, 32'h0000000A, 32'h00FA05DC,
      32'h00042710, 32'h012C0014, 32'h000927C0, 32'h00640050, 32'h000007D0,
      32'h000007D0, 32'h000007D0, 32'h000007D0};

   sssm_monitor #(.TICK_CYC(4)) DUT (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .measSpeed(measSpeed),
      .speedSetpoint(speedSetpoint), .stopSelect(stopSelect), .capSelect(capSelect),
      .capLevel(capLevel), .torqueCut(torqueCut), .quickStopRamp(quickStopRamp),
      .stopOneActive(stopOneActive), .rampOrAccelActive(rampOrAccelActive),
      .speedCapActive(speedCapActive), .clampedSetpoint(clampedSetpoint));
   sssm_drive_model MODEL (.sys_clk(sys_clk), .rst_b(rst_b), .torqueCut(torqueCut),
      .quickStopRamp(quickStopRamp), .clampedSetpoint(clampedSetpoint),
      .decelRate(decelRate), .measSpeed(measSpeed));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic completeRun();
      $display("checks %0d errors %0d", numChecks, numErrors);
      if (numErrors == 0 && numChecks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : completeRun

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         numErrors++;
         completeRun();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         numErrors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // entered just after a rising edge; returns just after one
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // ends when pready is seen high; only the bench timeout stops a wait that never sees it
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rdData = prdata;
      errBit = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb

   task automatic waitOut(input int sel, input int lim);
      int n;
      n = 0;
      while (outs[sel] !== 1'b1 && n < lim) begin
         @(posedge sys_clk);
         n++;
      end
      check(outs[sel], 1'b1);
   endtask : waitOut

   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      speedSetpoint = 16'sh0000;
      stopSelect = 1'b0;
      capSelect = 1'b0;
      capLevel = 2'h0;
      decelRate = 4'h2;
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      for (int i = 0; i < 11; i++) begin
         apb(1'b0, RA[i], 32'h0);
         check(rdData, RV[i]);
      end
      apb(1'b0, 8'h40, 32'h0);
      check({rdData[30:0], errBit}, 32'h1);
      speedSetpoint <= 16'sh0258;
      repeat (200) @(posedge sys_clk);
      stopSelect <= 1'b1;
      repeat (100) @(posedge sys_clk);
      check({stopOneActive, torqueCut}, 2'b00);
      // ramp stop; bad mode code refused
      apb(1'b1, A_RAMP, 32'h000505DC);
      apb(1'b1, A_CTRL, 32'h00000005);
      apb(1'b0, A_CTRL, 32'h0);
      check(rdData & 32'h6, 32'h2);
      apb(1'b1, A_CTRL, 32'h00000003);
      waitOut(1, 20);
      check(quickStopRamp, 1'b1);
      waitOut(2, 100);
      waitOut(0, 4000);
      check(stopOneActive, 1'b0);
      stopSelect <= 1'b0;
      waitOut(4, 40);
      repeat (200) @(posedge sys_clk);
      apb(1'b1, A_BCUT, 32'h00000014);
      apb(1'b1, A_CTRL, 32'h00000007);
      decelRate <= 4'h0;
      stopSelect <= 1'b1;
      waitOut(2, 20);
      cnt = 0;
      while (torqueCut !== 1'b1 && cnt < 200) begin
         @(posedge sys_clk);
         cnt++;
      end
      check(cnt >= 70 && cnt <= 90, 1'b1);
      stopSelect <= 1'b0;
      decelRate <= 4'h2;
      waitOut(4, 40);
      // level one only; cap clamp and fault
      apb(1'b1, A_CAPCFG, 32'h00050050);
      apb(1'b1, A_LVL0, 32'h000003E8);
      speedSetpoint <= 16'sh05DC;
      capLevel <= 2'h0;
      capSelect <= 1'b1;
      repeat (10) @(posedge sys_clk);
      check(quickStopRamp, 1'b1);
      waitOut(3, 60);
      repeat (250) @(posedge sys_clk);
      check({16'h0, clampedSetpoint}, 32'h00000320);
      apb(1'b1, A_LVL0, 32'h000001F4);
      waitOut(0, 100);
      capSelect <= 1'b0;
      waitOut(4, 40);
      // cap in mode 1: ramp watch before cap goes active
      apb(1'b1, A_CTRL, 32'h00000003);
      capSelect <= 1'b1;
      waitOut(2, 60);
      check(speedCapActive, 1'b0);
      waitOut(3, 400);
      check({16'h0, clampedSetpoint}, 32'h00000190);
      capSelect <= 1'b0;
      completeRun();
   end
endmodule : tb_sssm_monitor
